/* File: rps_pkg.sv */
// package: register map, field positions, reset values and timing of the reset/power supervisor
package rps_pkg;

    // ***********************************
    // register byte addresses
    // ***********************************
    localparam logic [7:0] ADDR_CAUSE    = 8'h00;
    localparam logic [7:0] ADDR_CTRL     = 8'h04;
    localparam logic [7:0] ADDR_MODE     = 8'h08;
    localparam logic [7:0] ADDR_USRCFG   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;

    // ***********************************
    // reset cause register fields
    // ***********************************
    localparam int FLAG_W     = 6;
    localparam int FLAG_PIN   = 0;
    localparam int FLAG_PWRON = 1;
    localparam int FLAG_BROWN = 2;
    localparam int FLAG_WDT   = 3;
    localparam int FLAG_SW    = 4;
    localparam int FLAG_BRK   = 5;
    localparam logic [FLAG_W-1:0] FLAGS_POR_VAL = 6'h06;

    // ***********************************
    // control register fields
    // ***********************************
    localparam int CTRL_BO_EN      = 0;
    localparam int CTRL_BO_IRQ     = 1;
    localparam int CTRL_SW_RST     = 2;
    localparam int CTRL_CMP_OFF    = 3;
    localparam int CTRL_RC_SYSCLK  = 4;
    localparam int CTRL_RTC_EN     = 5;
    localparam int CTRL_PORT_REL   = 6;
    localparam logic [6:0] CTRL_RST_VAL = 7'h01;

    // ***********************************
    // user config byte one fields
    // ***********************************
    localparam int UCFG_RPSEL   = 0;
    localparam int UCFG_BOLEVEL = 1;
    localparam logic [1:0] UCFG_RST_VAL = 2'h0;

    // ***********************************
    // status register fields
    // ***********************************
    localparam int ST_BO_COND   = 0;
    localparam int ST_POWERUP   = 1;
    localparam int ST_PIN       = 2;
    localparam int ST_MODE_LSB  = 4;

    // ***********************************
    // power modes, bus answers
    // ***********************************
    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_IDLE,
        PM_PD,
        PM_TPD
    } rps_mode_t;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ***********************************
    // timing
    // ***********************************
    localparam int CLK_HZ         = 20_000_000;
    localparam int POWERUP_NS     = 2000;
    localparam int RST_HOLD_NS    = 500;
    localparam int POWERUP_CYC    = (POWERUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RST_HOLD_CYC   = (RST_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W          = 8;

endpackage

/* File: rps_sync.sv */
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module rps_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* File: rps_top.sv */
// reset and power supervisor: reset sources, cause flags, shared pin, power modes
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module rps_top
    import rps_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int HOLD_CYCLES    = RST_HOLD_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // asynchronous pins and supply monitor
    input  wire logic        shared_reset_input_pin,
    input  wire logic        supply_below_trip,
    input  wire logic        power_on_detect,
    // same-clock reset and wake requests
    input  wire logic        watchdog_reset_req,
    input  wire logic        break_reset_req,
    input  wire logic        irq_pending,
    input  wire logic        wake_irq,
    // reset and interrupt outputs
    output logic             system_reset_n,
    output logic             brownout_irq,
    output logic             rtc_reset,
    output logic             shared_pin_data,
    output logic             ports_input_only,
    // power domain controls
    output logic             cpu_halt,
    output logic             main_osc_enable,
    output logic             rc_osc_enable,
    output logic             brownout_power,
    output logic             comparator_power,
    output logic             watchdog_run,
    output logic             rtc_run
);

    // ***********************************
    // synchronised pins
    // ***********************************
    logic [2:0] pins_s;
    logic       pin_s;
    logic       below_s;
    logic       pod_s;

    rps_sync #(
        .W       (3),
        .RST_VAL (3'h1)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({power_on_detect, supply_below_trip, shared_reset_input_pin}),
        .q       (pins_s)
    );

    assign pin_s   = pins_s[0];
    assign below_s = pins_s[1];
    assign pod_s   = pins_s[2];

    // ***********************************
    // state
    // ***********************************
    logic [FLAG_W-1:0] flags_q;
    logic [FLAG_W-1:0] flags_d;
    logic [6:0]        ctrl_q;
    logic [1:0]        ucfg_q;
    rps_mode_t         mode_q;
    rps_mode_t         mode_d;
    logic [CNT_W-1:0]  pwrup_cnt_q;
    logic [CNT_W-1:0]  hold_cnt_q;
    logic              pod_prev_q;
    logic              sw_req_q;

    // ***********************************
    // bus decode
    // ***********************************
    wire wr_go    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_go    = s_axi_arvalid && !s_axi_rvalid;
    wire wr_lane0 = wr_go && s_axi_wstrb[0];
    wire wr_cause = wr_lane0 && (s_axi_awaddr == ADDR_CAUSE);
    wire wr_ctrl  = wr_lane0 && (s_axi_awaddr == ADDR_CTRL);
    wire wr_mode  = wr_lane0 && (s_axi_awaddr == ADDR_MODE);
    wire wr_ucfg  = wr_lane0 && (s_axi_awaddr == ADDR_USRCFG);
    wire wr_hit   = (s_axi_awaddr == ADDR_CAUSE) || (s_axi_awaddr == ADDR_CTRL) ||
                    (s_axi_awaddr == ADDR_MODE) || (s_axi_awaddr == ADDR_USRCFG) ||
                    (s_axi_awaddr == ADDR_STATUS);
    wire rd_hit   = (s_axi_araddr == ADDR_CAUSE) || (s_axi_araddr == ADDR_CTRL) ||
                    (s_axi_araddr == ADDR_MODE) || (s_axi_araddr == ADDR_USRCFG) ||
                    (s_axi_araddr == ADDR_STATUS);

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;

    // ***********************************
    // reset sources
    // ***********************************
    wire bo_en      = ctrl_q[CTRL_BO_EN];
    wire bo_irq_sel = ctrl_q[CTRL_BO_IRQ];
    wire in_powerup = (pwrup_cnt_q != '0);
    // gated by enable; detector off in total power-down
    wire bo_cond    = bo_en && below_s && (mode_q != PM_TPD);
    wire bo_rst     = bo_cond && !bo_irq_sel;
    // pin acts as reset when selected or during power-up
    wire pin_is_rst = in_powerup || ucfg_q[UCFG_RPSEL];
    wire pin_rst    = pin_is_rst && !pin_s;
    // edge of power-on detect is a power-on reset
    wire por_evt    = pod_s && !pod_prev_q;
    wire any_rst    = pin_rst || bo_rst || watchdog_reset_req || sw_req_q ||
                      break_reset_req || por_evt;

    // ***********************************
    // cause flags
    // ***********************************
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_keep;

    // one flag bit per non-power-on source
    assign flag_set = {break_reset_req, sw_req_q, watchdog_reset_req, bo_rst, 1'b0, pin_rst};
    // writing zero clears, writing one keeps
    assign flag_keep = wr_cause ? s_axi_wdata[FLAG_W-1:0] : {FLAG_W{1'b1}};
    // power-on sets power-on and brownout only; set wins over clear
    assign flags_d = por_evt ? FLAGS_POR_VAL : ((flags_q & flag_keep) | flag_set);

    always_ff @(posedge aclk) begin
        // power-on flag held from power-up until cleared
        if (!aresetn) begin
            flags_q <= FLAGS_POR_VAL;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ***********************************
    // control and configuration
    // ***********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q     <= CTRL_RST_VAL;
            ucfg_q     <= UCFG_RST_VAL;
            sw_req_q   <= 1'b0;
            pod_prev_q <= 1'b0;
        end else begin
            pod_prev_q <= pod_s;
            sw_req_q   <= wr_ctrl && s_axi_wdata[CTRL_SW_RST];
            if (por_evt) begin
                ctrl_q <= CTRL_RST_VAL;
            end else if (wr_ctrl) begin
                ctrl_q <= s_axi_wdata[6:0] & ~(7'h01 << CTRL_SW_RST);
            end
            if (wr_ucfg) begin
                ucfg_q <= s_axi_wdata[1:0];
            end
        end
    end

    // ***********************************
    // power-up window and reset stretch
    // ***********************************
    always_ff @(posedge aclk) begin
        // power-up window restarts on every power-on
        if (!aresetn) begin
            pwrup_cnt_q <= CNT_W'(POWERUP_CYCLES);
        end else if (por_evt) begin
            pwrup_cnt_q <= CNT_W'(POWERUP_CYCLES);
        end else if (in_powerup) begin
            pwrup_cnt_q <= pwrup_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_cnt_q <= CNT_W'(HOLD_CYCLES);
        end else if (any_rst || in_powerup) begin
            hold_cnt_q <= CNT_W'(HOLD_CYCLES);
        end else if (hold_cnt_q != '0) begin
            hold_cnt_q <= hold_cnt_q - 1'b1;
        end
    end

    // ***********************************
    // power mode sequencer
    // ***********************************
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            PM_ACTIVE: begin
                if (wr_mode && !any_rst) begin
                    mode_d = rps_mode_t'(s_axi_wdata[1:0]);
                end
            end
            // enabled interrupt or reset ends idle
            PM_IDLE: begin
                if (any_rst || irq_pending) begin
                    mode_d = PM_ACTIVE;
                end
            end
            // any reset or qualifying interrupt wakes
            PM_PD, PM_TPD: begin
                if (any_rst || wake_irq) begin
                    mode_d = PM_ACTIVE;
                end
            end
            default: begin
                mode_d = PM_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= PM_ACTIVE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ***********************************
    // registered outputs
    // ***********************************
    wire pd_any  = (mode_q == PM_PD) || (mode_q == PM_TPD);
    wire rc_keep = ctrl_q[CTRL_RC_SYSCLK] && ctrl_q[CTRL_RTC_EN];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_reset_n   <= 1'b0;
            brownout_irq     <= 1'b0;
            rtc_reset        <= 1'b1;
            shared_pin_data  <= 1'b1;
            ports_input_only <= 1'b1;
            cpu_halt         <= 1'b0;
            main_osc_enable  <= 1'b1;
            rc_osc_enable    <= 1'b1;
            brownout_power   <= 1'b1;
            comparator_power <= 1'b1;
            watchdog_run     <= 1'b1;
            rtc_run          <= 1'b0;
        end else begin
            system_reset_n   <= !(any_rst || in_powerup || (hold_cnt_q != '0));
            // interrupt mode raises request instead of reset
            brownout_irq     <= bo_cond && bo_irq_sel;
            // only power-on resets the real-time clock
            rtc_reset        <= por_evt;
            shared_pin_data  <= pin_is_rst ? 1'b1 : pin_s;
            // pins input only until software releases them
            ports_input_only <= por_evt ? 1'b1 : !ctrl_q[CTRL_PORT_REL];
            cpu_halt         <= (mode_q != PM_ACTIVE);
            main_osc_enable  <= !pd_any;
            // rc oscillator kept only as system clock with rtc
            rc_osc_enable    <= !pd_any || rc_keep;
            // brownout and comparator survive power-down only
            brownout_power   <= bo_en && (mode_q != PM_TPD);
            comparator_power <= !ctrl_q[CTRL_CMP_OFF] && (mode_q != PM_TPD);
            watchdog_run     <= 1'b1;
            rtc_run          <= ctrl_q[CTRL_RTC_EN];
        end
    end

    // ***********************************
    // bus responses
    // ***********************************
    logic [31:0] rd_mux;

    assign rd_mux =
        (s_axi_araddr == ADDR_CAUSE)  ? {26'h0, flags_q} :
        (s_axi_araddr == ADDR_CTRL)   ? {25'h0, ctrl_q} :
        (s_axi_araddr == ADDR_MODE)   ? {30'h0, mode_q} :
        (s_axi_araddr == ADDR_USRCFG) ? {30'h0, ucfg_q} :
        (s_axi_araddr == ADDR_STATUS) ? {26'h0, mode_q, 1'b0, pin_s, in_powerup, bo_cond} :
        32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata  <= rd_mux;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_por_seen;
        por_evt;
    endsequence
    sequence seq_enter_pd;
        (mode_q == PM_ACTIVE) ##1 (mode_q == PM_PD);
    endsequence

    chk_por_flags: assert property (seq_por_seen |=> flags_q == FLAGS_POR_VAL)
        else $error("power-on did not load power-on and brownout flags");
    chk_flags_sticky: assert property (!por_evt && !wr_cause |=>
        ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("uncleared cause flag was lost");
    chk_flag_clear: assert property (wr_cause && !por_evt && !s_axi_wdata[FLAG_PWRON] |=>
        !flags_q[FLAG_PWRON])
        else $error("write of zero did not clear power-on flag");
    chk_bo_disabled: assert property (!bo_en |=> !brownout_irq && !$past(bo_rst))
        else $error("brownout acted while disabled");
    chk_bo_irq_mode: assert property (bo_en && below_s && bo_irq_sel && mode_q != PM_TPD
        |=> brownout_irq && (flags_q[FLAG_BROWN] == $past(flags_d[FLAG_BROWN])))
        else $error("brownout interrupt mode did not raise request");
    chk_bo_reset: assert property (bo_rst |=> !system_reset_n && flags_q[FLAG_BROWN])
        else $error("brownout condition did not reset and flag");
    chk_idle_wake: assert property (mode_q == PM_IDLE && irq_pending |=>
        mode_q == PM_ACTIVE ##1 !cpu_halt)
        else $error("idle not ended by interrupt");
    chk_pd_osc: assert property (seq_enter_pd ##1 (mode_q == PM_PD) |->
        !main_osc_enable && cpu_halt && watchdog_run)
        else $error("main oscillator still running in power-down");
    chk_tpd_off: assert property (mode_q == PM_TPD |=> !brownout_power && !comparator_power)
        else $error("brownout or comparator powered in total power-down");
    chk_rc_osc: assert property (pd_any && !rc_keep |=> !rc_osc_enable)
        else $error("rc oscillator left on in power-down");
    chk_pin_select: assert property (!in_powerup && !ucfg_q[UCFG_RPSEL] |-> !pin_rst)
        else $error("shared pin reset without select outside power-up");
    chk_pin_powerup: assert property (in_powerup && !pin_s |-> pin_rst ##1 !system_reset_n)
        else $error("shared pin low in power-up did not reset");
    chk_rtc_por: assert property (!por_evt |=> !rtc_reset)
        else $error("real-time clock reset without power-on");

endmodule
`default_nettype wire

/* File: rps_supply_model.sv */
// model of the supply monitor and the external reset circuit
`timescale 1ns/1ns
`default_nettype none
module rps_supply_model (
    // clock
    input  wire logic aclk,
    // commands from the bench
    input  wire logic por_cmd,
    input  wire logic pin_cmd,
    input  wire logic bo_cmd,
    // monitor and pin levels
    output var logic  power_on_detect,
    output var logic  shared_reset_input_pin,
    output var logic  supply_below_trip
);
    always @(posedge aclk) begin
        power_on_detect <= por_cmd;
        shared_reset_input_pin <= ~pin_cmd;
        supply_below_trip <= bo_cmd;
    end
endmodule
`default_nettype wire

/* File: rps_top_tb.sv */
// self-checking bench of the reset and power supervisor
`timescale 1ns/1ns
`default_nettype none
module rps_top_tb
    import rps_pkg::*;
;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, rnd = 32'hd28d_8884;
    logic [3:0]  s_axi_wstrb = '0;
    logic [1:0]  rq = '0;
    logic        irq_pending = 0, wake_irq = 0, por_cmd = 0, pin_cmd = 0, bo_cmd = 0;
    logic        clr = 0, rst_seen = 0, rtc_seen = 0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic   shared_reset_input_pin, supply_below_trip, power_on_detect;
    wire logic   system_reset_n, brownout_irq, rtc_reset, shared_pin_data, ports_input_only;
    wire logic   cpu_halt, main_osc_enable, rc_osc_enable, brownout_power;
    wire logic   comparator_power, watchdog_run, rtc_run;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    logic [31:0] expq [$];
    int          n_errors = 0, checks_done = 0;

    initial begin
        forever #25 aclk = ~aclk;
    end
    rps_top #(.POWERUP_CYCLES(4), .HOLD_CYCLES(2)) DUT (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .shared_reset_input_pin, .supply_below_trip,
        .power_on_detect, .watchdog_reset_req(rq[0]), .break_reset_req(rq[1]),
        .irq_pending, .wake_irq, .system_reset_n, .brownout_irq, .rtc_reset,
        .shared_pin_data, .ports_input_only, .cpu_halt, .main_osc_enable, .rc_osc_enable,
        .brownout_power, .comparator_power, .watchdog_run, .rtc_run);
    rps_supply_model PSM (.aclk, .por_cmd, .pin_cmd, .bo_cmd, .power_on_detect,
        .shared_reset_input_pin, .supply_below_trip);

    // ***********************************
    // checking and bus tasks
    // ***********************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && s_axi_awready !== 1'h1) ||
                   (s_axi_wvalid && s_axi_wready !== 1'h1));
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        chk("bresp", s_axi_bresp, er);
        s_axi_bready <= 1'h0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        expq.push_back(e);
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
    endtask
    task automatic wait_rel();
        do @(posedge aclk); while (system_reset_n !== 1'h1);
    endtask
    task automatic pulse(input logic [1:0] v);
        @(posedge aclk);
        rq <= v;
        @(posedge aclk);
        rq <= 2'h0;
        tick(2);
        wait_rel();
    endtask
    task automatic clear_seen();
        @(posedge aclk);
        clr <= 1'h1;
        @(posedge aclk);
        clr <= 1'h0;
    endtask

    // read monitor and event latches
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1 && expq.size() > 0) begin
            chk("rdata", s_axi_rdata, expq.pop_front());
            chk("rresp", s_axi_rresp, RESP_OKAY);
        end
        rst_seen <= clr ? 1'h0 : (rst_seen | (system_reset_n === 1'h0));
        rtc_seen <= clr ? 1'h0 : (rtc_seen | (rtc_reset === 1'h1));
    end

    // ***********************************
    // main sequence
    // ***********************************
    initial begin
        tick(5);
        aresetn <= 1'h1;
        wait_rel();
        axr(ADDR_CAUSE, 32'h0000_0006);
        chk("ports_input_only", ports_input_only, 1'h1);
        axw(ADDR_CTRL, 32'h0000_0041, RESP_OKAY);
        tick(2);
        chk("ports_input_only", ports_input_only, 1'h0);
        clear_seen();
        pulse(2'h1);
        axr(ADDR_CAUSE, 32'h0000_000e);
        axw(ADDR_CAUSE, 32'h0000_0000, RESP_OKAY);
        axr(ADDR_CAUSE, 32'h0000_0000);
        axw(ADDR_CTRL, 32'h0000_0045, RESP_OKAY);
        tick(2);
        wait_rel();
        pulse(2'h2);
        axr(ADDR_CAUSE, 32'h0000_0030);
        chk("rtc_reset", rtc_seen, 1'h0);
        axw(ADDR_CAUSE, 32'h0000_0020, RESP_OKAY);
        rnd = lfsr(rnd);
        axw(8'h14, rnd, RESP_SLVERR);
        axr(ADDR_USRCFG, 32'h0000_0000);
        clear_seen();
        pin_cmd <= 1'h1;
        tick(6);
        chk("shared_pin_data", shared_pin_data, 1'h0);
        chk("pin reset", rst_seen, 1'h0);
        pin_cmd <= 1'h0;
        tick(4);
        axw(ADDR_USRCFG, 32'h0000_0001, RESP_OKAY);
        pin_cmd <= 1'h1;
        tick(6);
        chk("pin reset", rst_seen, 1'h1);
        pin_cmd <= 1'h0;
        wait_rel();
        axr(ADDR_CAUSE, 32'h0000_0021);
        bo_cmd <= 1'h1;
        tick(6);
        chk("system_reset_n", system_reset_n, 1'h0);
        bo_cmd <= 1'h0;
        wait_rel();
        axr(ADDR_CAUSE, 32'h0000_0025);
        axw(ADDR_CTRL, 32'h0000_0043, RESP_OKAY);
        clear_seen();
        bo_cmd <= 1'h1;
        tick(6);
        chk("brownout_irq", brownout_irq, 1'h1);
        bo_cmd <= 1'h0;
        tick(6);
        chk("brownout_irq", brownout_irq, 1'h0);
        axw(ADDR_CTRL, 32'h0000_0042, RESP_OKAY);
        bo_cmd <= 1'h1;
        tick(6);
        chk("brownout_irq", brownout_irq, 1'h0);
        chk("bo reset", rst_seen, 1'h0);
        bo_cmd <= 1'h0;
        axw(ADDR_MODE, 32'h0000_0001, RESP_OKAY);
        tick(2);
        chk("cpu_halt", cpu_halt, 1'h1);
        irq_pending <= 1'h1;
        tick(3);
        chk("cpu_halt", cpu_halt, 1'h0);
        irq_pending <= 1'h0;
        axw(ADDR_CTRL, 32'h0000_0041, RESP_OKAY);
        axw(ADDR_MODE, 32'h0000_0002, RESP_OKAY);
        tick(2);
        chk("main_osc_enable", main_osc_enable, 1'h0);
        chk("rc_osc_enable", rc_osc_enable, 1'h0);
        chk("pd alive", {brownout_power, watchdog_run, comparator_power}, 3'h7);
        wake_irq <= 1'h1;
        tick(3);
        chk("main_osc_enable", main_osc_enable, 1'h1);
        wake_irq <= 1'h0;
        axw(ADDR_CTRL, 32'h0000_0071, RESP_OKAY);
        axw(ADDR_MODE, 32'h0000_0003, RESP_OKAY);
        tick(2);
        chk("rc_osc_enable", rc_osc_enable, 1'h1);
        chk("tpd off", {brownout_power, comparator_power}, 2'h0);
        chk("rtc_run", rtc_run, 1'h1);
        pulse(2'h1); // wake through reset
        chk("main_osc_enable", main_osc_enable, 1'h1);
        axr(ADDR_MODE, 32'h0000_0000);
        clear_seen();
        por_cmd <= 1'h1;
        tick(8);
        wait_rel();
        chk("rtc_reset", rtc_seen, 1'h1);
        chk("ports_input_only", ports_input_only, 1'h1);
        axr(ADDR_CAUSE, 32'h0000_0006);
        // pin low through the power-up window and past its end, select cleared
        por_cmd <= 1'h0;
        axw(ADDR_USRCFG, 32'h0000_0000, RESP_OKAY);
        por_cmd <= 1'h1;
        pin_cmd <= 1'h1;
        tick(8);
        pin_cmd <= 1'h0;
        wait_rel();
        axr(ADDR_CAUSE, 32'h0000_0007);
        close_out();
    end

    // hang guard
    initial begin
        tick(20000);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
